// >>> acl_rew_pkg.sv
// Constants, register map and mode codes of the access-list frame header rewriter.
package acl_rew_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWAP = 8'h04;
  localparam logic [7:0] ADDR_PORT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_DOM_BASE = 8'h40;
  localparam logic [7:0] ADDR_SIP_BASE = 8'h80;
  localparam int DOM_N = 4;
  localparam int SIP_N = 32;

  // Control register bits.
  localparam int CTRL_RT_SEL = 0;
  localparam int CTRL_ERLEG = 1;
  localparam int CTRL_EVID = 2;
  localparam int CTRL_PTP_ALLOW = 3;
  localparam int CTRL_MC_UPD = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;

  // Swap control fields: IPv4 TTL [7:0], IPv6 hop limit [15:8], DMAC bits [21:16].
  localparam int SWAP_HOP6_LSB = 8;
  localparam int SWAP_DBITS_LSB = 16;
  localparam logic [31:0] SWAP_RST = 32'h0000_4040;

  // Port config: time domain [1:0], port number low bits [9:4], use them [12].
  localparam int PORT_NUM_LSB = 4;
  localparam int PORT_NUM_ENA = 12;
  localparam logic [31:0] PORT_RST = 32'h0000_0000;

  // Per-domain word offsets: clock id high, clock id low, port number, flags.
  localparam logic [1:0] DOM_CLK_HI = 2'h0;
  localparam logic [1:0] DOM_CLK_LO = 2'h1;
  localparam logic [1:0] DOM_PORT = 2'h2;
  localparam logic [1:0] DOM_FLAG = 2'h3;

  // --------------------------------------------------------------------------
  // Frame constants
  // --------------------------------------------------------------------------
  localparam int MAC_MC_BIT = 40;
  localparam int RC_DMAC_PART = 9;
  localparam logic [1:0] DLY_TS = 2'h1;
  localparam logic [1:0] DLY_NOTS = 2'h2;
  localparam logic [3:0] PTP_TYPE_RESP = 4'h9;
  localparam logic [7:0] PTP_CTRL_RESP = 8'h03;
  localparam logic [15:0] PTP_LEN_RESP = 16'h0054;
  localparam logic [15:0] PTP_GROW = 16'h000a;
  localparam logic [15:0] FRAME_MAX = 16'h0094;
  localparam logic [15:0] UDP_LEN_REQ = 16'h002c;

  typedef enum logic [3:0] {
    RT_NONE = 4'h0,
    RT_REPL_DMAC = 4'h1,
    RT_REPL_SMAC = 4'h2,
    RT_SWAP_MAC = 4'h3,
    RT_CSWAP_MAC = 4'h4,
    RT_SWAP_MAC_IP = 4'h5,
    RT_CSWAP_MAC_IP = 4'h6,
    RT_SWAP_IP = 4'h7,
    RT_SMAC_SWAP_IP = 4'h8,
    RT_ROUTE = 4'h9
  } rt_mode_t;

endpackage

// >>> acl_frame_header_rewriter.sv
// Header rewrite stage: address swaps, routing updates and delay response build.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module acl_frame_header_rewriter
  import acl_rew_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Parsed header
  input wire logic i_hdr_valid,
  input wire logic [47:0] i_dmac,
  input wire logic [47:0] i_smac,
  input wire logic i_is_ip4,
  input wire logic i_is_ip6,
  input wire logic i_is_l4,
  input wire logic i_is_udp,
  input wire logic [127:0] i_sip,
  input wire logic [127:0] i_dip,
  input wire logic [7:0] i_ttl,
  input wire logic [15:0] i_sport,
  input wire logic [15:0] i_dport,
  input wire logic [15:0] i_ip_len,
  input wire logic [15:0] i_udp_len,
  input wire logic [15:0] i_frame_len,
  input wire logic [11:0] i_cl_vid,
  input wire logic [9:0] i_cl_vsi,
  // Parsed delay request
  input wire logic i_is_dreq,
  input wire logic [15:0] i_ptp_flags,
  input wire logic [79:0] i_ptp_src_id,
  input wire logic [79:0] i_ptp_rx_ts,
  input wire logic [7:0] i_ptp_log_int,
  input wire logic [3:0][79:0] i_ing_ts,
  // Classifier action
  input wire logic [3:0] i_action_routing_mode,
  input wire logic [47:0] i_action_mac_value,
  input wire logic [9:0] i_rewrite_command,
  input wire logic i_policer_enable,
  input wire logic [4:0] i_policer_index,
  input wire logic i_act2_policer_enable,
  input wire logic [4:0] i_act2_policer_index,
  input wire logic i_hop_preset_enable,
  input wire logic i_port_rewrite_enable,
  input wire logic [15:0] i_match_identifier,
  input wire logic [15:0] i_match_identifier_mask,
  input wire logic [1:0] i_time_domain_select,
  input wire logic i_mac_exchange_flag,
  input wire logic [2:0] i_interval_value_field,
  // Layer-3 analyzer results
  input wire logic [47:0] i_nh_mac,
  input wire logic [11:0] i_egr_vid,
  input wire logic [9:0] i_egr_rleg,
  // Rewritten header
  output logic o_valid,
  output logic [47:0] o_dmac,
  output logic [47:0] o_smac,
  output logic [127:0] o_sip,
  output logic [127:0] o_dip,
  output logic [7:0] o_ttl,
  output logic [15:0] o_sport,
  output logic [15:0] o_dport,
  output logic [15:0] o_ip_len,
  output logic [15:0] o_udp_len,
  output logic [15:0] o_frame_len,
  output logic [11:0] o_cl_vid,
  output logic [9:0] o_cl_vsi,
  output logic [4:0] o_policer_index,
  output logic o_skip_dmac_rew,
  output logic o_ip4_csum_redo,
  output logic o_udp_csum_redo,
  output logic o_udp_csum_zero,
  output logic o_fcs_regen,
  output logic o_discard,
  // Rewritten delay response
  output logic o_dresp,
  output logic [3:0] o_ptp_type,
  output logic [7:0] o_ptp_ctrl,
  output logic [15:0] o_ptp_len,
  output logic [15:0] o_ptp_flags,
  output logic [79:0] o_ptp_src_id,
  output logic [79:0] o_ptp_req_id,
  output logic [79:0] o_ptp_rx_ts,
  output logic [7:0] o_ptp_log_int
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_r, swap_r, port_r;
  logic [15:0] resp_cnt_r, disc_cnt_r;
  logic [31:0] sip_r [SIP_N];
  logic [31:0] dom_r [DOM_N*4];

  function automatic logic in_sip(input logic [7:0] a);
    return a[7] & (a[1:0] == 2'h0);
  endfunction

  function automatic logic in_dom(input logic [7:0] a);
    return (a[7:6] == ADDR_DOM_BASE[7:6]) & (a[1:0] == 2'h0);
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST;
      swap_r <= SWAP_RST;
      port_r <= PORT_RST;
      for (int k = 0; k < SIP_N; k++) begin
        sip_r[k] <= 32'h0;
      end
      for (int k = 0; k < DOM_N*4; k++) begin
        dom_r[k] <= 32'h0;
      end
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_CTRL) ctrl_r <= i_reg_wdata;
      if (i_reg_addr == ADDR_SWAP) swap_r <= i_reg_wdata;
      if (i_reg_addr == ADDR_PORT) port_r <= i_reg_wdata;
      if (in_sip(i_reg_addr)) sip_r[i_reg_addr[6:2]] <= i_reg_wdata;
      if (in_dom(i_reg_addr)) dom_r[i_reg_addr[5:2]] <= i_reg_wdata;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads zero.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_reg_rd) begin
      o_reg_rdata <= 32'h0;
    end else if (in_sip(i_reg_addr)) begin
      o_reg_rdata <= sip_r[i_reg_addr[6:2]];
    end else if (in_dom(i_reg_addr)) begin
      o_reg_rdata <= dom_r[i_reg_addr[5:2]];
    end else begin
      case (i_reg_addr)
        ADDR_CTRL: o_reg_rdata <= ctrl_r;
        ADDR_SWAP: o_reg_rdata <= swap_r;
        ADDR_PORT: o_reg_rdata <= port_r;
        ADDR_STAT: o_reg_rdata <= {disc_cnt_r, resp_cnt_r};
        default: o_reg_rdata <= 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Address rewrite
  // --------------------------------------------------------------------------
  function automatic logic ip_mc(input logic [127:0] a, input logic v6);
    return v6 ? (a[127:120] == 8'hff) : (a[31:28] == 4'he);
  endfunction

  rt_mode_t mode;
  logic is_ip, ip_chg, rt_on, dly, hop_chg, port_chg, mc_in;
  logic [4:0] idx;
  logic [5:0] dbits;
  logic [47:0] dmask;
  logic [127:0] tbl_ip;
  logic [1:0] dsel;
  logic [15:0] fmask, grown;
  logic [47:0] dmac_nxt, smac_nxt;
  logic [127:0] sip_nxt, dip_nxt;

  assign mode = rt_mode_t'(i_action_routing_mode);
  assign is_ip = i_is_ip4 | i_is_ip6;
  assign idx = i_act2_policer_enable ? i_act2_policer_index : i_policer_index;
  assign dbits = swap_r[SWAP_DBITS_LSB +: 6];
  assign dmask = ~(48'hffff_ffff_ffff >> dbits);
  assign mc_in = i_dmac[MAC_MC_BIT];
  assign tbl_ip = i_is_ip6 ?
    {sip_r[{idx[2:0], 2'h0}], sip_r[{idx[2:0], 2'h1}],
     sip_r[{idx[2:0], 2'h2}], sip_r[{idx[2:0], 2'h3}]} : {96'h0, sip_r[idx]};

  always_comb begin
    dmac_nxt = i_dmac;
    smac_nxt = i_smac;
    sip_nxt = i_sip;
    dip_nxt = i_dip;
    ip_chg = 1'b0;
    case (mode)
      RT_REPL_DMAC: begin
        dmac_nxt = i_rewrite_command[RC_DMAC_PART] ?
          ((i_dmac & ~dmask) | (i_action_mac_value & dmask)) : i_action_mac_value;
      end
      RT_REPL_SMAC: begin
        smac_nxt = i_action_mac_value;
      end
      RT_SWAP_MAC, RT_SWAP_MAC_IP: begin
        dmac_nxt = i_smac;
        smac_nxt = mc_in ? i_action_mac_value : i_dmac;
      end
      RT_CSWAP_MAC, RT_CSWAP_MAC_IP: begin
        dmac_nxt = mc_in ? i_dmac : i_smac;
        smac_nxt = mc_in ? i_action_mac_value : i_dmac;
      end
      RT_SMAC_SWAP_IP: begin
        smac_nxt = i_action_mac_value;
      end
      default: begin
        dmac_nxt = i_dmac;
      end
    endcase
    if (is_ip) begin
      case (mode)
        RT_SWAP_MAC_IP, RT_SWAP_IP, RT_SMAC_SWAP_IP: begin
          ip_chg = 1'b1;
          dip_nxt = i_sip;
          sip_nxt = ip_mc(i_dip, i_is_ip6) ? tbl_ip : i_dip;
        end
        RT_CSWAP_MAC_IP: begin
          ip_chg = 1'b1;
          dip_nxt = ip_mc(i_dip, i_is_ip6) ? i_dip : i_sip;
          sip_nxt = ip_mc(i_dip, i_is_ip6) ? tbl_ip : i_dip;
        end
        default: begin
          ip_chg = 1'b0;
        end
      endcase
    end
    if (rt_on) dmac_nxt = i_nh_mac;
  end

  assign rt_on = ctrl_r[CTRL_RT_SEL] | (mode == RT_ROUTE);
  assign hop_chg = ip_chg & i_hop_preset_enable;
  assign port_chg = i_port_rewrite_enable & is_ip & i_is_l4;
  assign dly = i_is_dreq & ctrl_r[CTRL_PTP_ALLOW] &
    ((i_rewrite_command[1:0] == DLY_TS) | (i_rewrite_command[1:0] == DLY_NOTS));
  assign dsel = i_time_domain_select;
  assign fmask = dom_r[{dsel, DOM_FLAG}][31:16];
  assign grown = i_frame_len + PTP_GROW;

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_dmac <= 48'h0;
      o_smac <= 48'h0;
      o_sip <= 128'h0;
      o_dip <= 128'h0;
      o_ttl <= 8'h0;
      o_sport <= 16'h0;
      o_dport <= 16'h0;
      o_cl_vid <= 12'h0;
      o_cl_vsi <= 10'h0;
      o_policer_index <= 5'h0;
      o_skip_dmac_rew <= 1'b0;
      o_ip4_csum_redo <= 1'b0;
      o_udp_csum_redo <= 1'b0;
      o_udp_csum_zero <= 1'b0;
      o_fcs_regen <= 1'b0;
    end else begin
      o_valid <= i_hdr_valid;
      o_dmac <= dmac_nxt;
      o_smac <= smac_nxt;
      o_sip <= sip_nxt;
      o_dip <= dip_nxt;
      o_ttl <= !hop_chg ? i_ttl :
        (i_is_ip4 ? swap_r[7:0] : swap_r[SWAP_HOP6_LSB +: 8]);
      o_sport <= port_chg ? i_match_identifier : i_sport;
      o_dport <= port_chg ? i_match_identifier_mask : i_dport;
      o_cl_vid <= rt_on ? i_egr_vid : i_cl_vid;
      o_cl_vsi <= (rt_on & ctrl_r[CTRL_ERLEG]) ? i_egr_rleg :
        (rt_on & ctrl_r[CTRL_EVID]) ? i_egr_vid[9:0] : i_cl_vsi;
      o_policer_index <= idx;
      o_skip_dmac_rew <= rt_on;
      o_ip4_csum_redo <= i_is_ip4 & (ip_chg | hop_chg | dly);
      o_udp_csum_redo <= i_is_ip6 & i_is_udp & (ip_chg | port_chg | dly);
      o_udp_csum_zero <= i_is_ip4 & i_is_udp & (ip_chg | port_chg | dly);
      o_fcs_regen <= ip_chg | hop_chg | port_chg | dly | rt_on | (mode != RT_NONE);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dresp <= 1'b0;
      o_discard <= 1'b0;
      o_ptp_type <= 4'h0;
      o_ptp_ctrl <= 8'h0;
      o_ptp_len <= 16'h0;
      o_ptp_flags <= 16'h0;
      o_ptp_src_id <= 80'h0;
      o_ptp_req_id <= 80'h0;
      o_ptp_rx_ts <= 80'h0;
      o_ptp_log_int <= 8'h0;
      o_frame_len <= 16'h0;
      o_udp_len <= 16'h0;
      o_ip_len <= 16'h0;
    end else begin
      o_dresp <= i_hdr_valid & dly;
      o_discard <= i_hdr_valid & dly & (grown > FRAME_MAX);
      o_ptp_type <= dly ? PTP_TYPE_RESP : 4'h0;
      o_ptp_ctrl <= dly ? PTP_CTRL_RESP : 8'h0;
      o_ptp_len <= dly ? PTP_LEN_RESP : 16'h0;
      o_ptp_flags <= (i_ptp_flags & ~fmask) | (dom_r[{dsel, DOM_FLAG}][15:0] & fmask);
      o_ptp_src_id <= {dom_r[{dsel, DOM_CLK_HI}], dom_r[{dsel, DOM_CLK_LO}],
        dom_r[{dsel, DOM_PORT}][15:6], port_r[PORT_NUM_ENA] ?
        port_r[PORT_NUM_LSB +: 6] : dom_r[{dsel, DOM_PORT}][5:0]};
      o_ptp_req_id <= i_ptp_src_id;
      o_ptp_rx_ts <= (i_rewrite_command[1:0] == DLY_TS) ?
        i_ing_ts[port_r[1:0]] : i_ptp_rx_ts;
      o_ptp_log_int <= (mc_in & ctrl_r[CTRL_MC_UPD]) ?
        {{5{i_mac_exchange_flag}}, i_interval_value_field} : i_ptp_log_int;
      o_frame_len <= dly ? grown : i_frame_len;
      o_udp_len <= (dly & i_is_udp) ? i_udp_len + PTP_GROW : i_udp_len;
      o_ip_len <= (dly & i_is_ip4) ? i_ip_len + PTP_GROW : i_ip_len;
    end
  end

  // --------------------------------------------------------------------------
  // Status counters
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      resp_cnt_r <= 16'h0;
      disc_cnt_r <= 16'h0;
    end else begin
      resp_cnt_r <= resp_cnt_r + {15'h0, o_dresp & ~o_discard};
      disc_cnt_r <= disc_cnt_r + {15'h0, o_discard};
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_dreq_taken;
    i_hdr_valid && dly;
  endsequence

  sequence s_resp_built;
    o_dresp && o_ptp_type == 4'h9 && o_ptp_ctrl == 8'h03 && o_ptp_len == 16'h0054;
  endsequence

  AST_RESP_FIELDS: assert property (s_dreq_taken |=> s_resp_built)
    else $error("delay response fields wrong");
  AST_RESP_GATE: assert property (o_dresp |-> $past(ctrl_r[CTRL_PTP_ALLOW]))
    else $error("response without global enable");
  AST_DISCARD: assert property (o_discard |-> o_dresp && o_frame_len > 16'h0094)
    else $error("discard without oversize");
  AST_UDP_GROW: assert property (
      o_dresp && $past(i_is_udp) |-> o_udp_len == $past(i_udp_len) + 16'h000a)
    else $error("udp length not grown");
  AST_SMAC_REPL: assert property (
      i_hdr_valid && mode == RT_REPL_SMAC && !rt_on
      |=> o_smac == $past(i_action_mac_value) && o_dmac == $past(i_dmac))
    else $error("source mac not replaced");
  AST_SWAP_MAC: assert property (
      mode == RT_SWAP_MAC && !rt_on && !mc_in
      |=> o_dmac == $past(i_smac) && o_smac == $past(i_dmac))
    else $error("mac swap wrong");
  AST_COND_KEEP: assert property (
      mode == RT_CSWAP_MAC && mc_in && !rt_on
      |=> o_dmac == $past(i_dmac) && o_smac == $past(i_action_mac_value))
    else $error("multicast dmac not kept");
  AST_ROUTE: assert property (
      rt_on |=> o_skip_dmac_rew && o_dmac == $past(i_nh_mac) && o_cl_vid == $past(i_egr_vid))
    else $error("routing update missing");
  AST_PORTS: assert property (port_chg |=> o_sport == $past(i_match_identifier))
    else $error("port not rewritten");
  AST_UDP4_ZERO: assert property (o_udp_csum_zero |-> !o_udp_csum_redo)
    else $error("udp checksum both cleared and redone");
  AST_FCS: assert property (
      o_valid && (o_dmac != $past(i_dmac) || o_smac != $past(i_smac)
      || o_sip != $past(i_sip) || o_frame_len != $past(i_frame_len)) |-> o_fcs_regen)
    else $error("changed frame without fcs regen");

endmodule // acl_frame_header_rewriter

`default_nettype wire

// >>> acl_egress_sink.sv
// Downstream egress model that accepts rewritten headers and tallies delay responses.
`timescale 1ns/10ps
`default_nettype none
module acl_egress_sink (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Rewritten header status
  input wire logic i_valid,
  input wire logic i_dresp,
  input wire logic i_discard,
  // Tallies
  output logic [15:0] o_resp_cnt
);
  // Only responses that survive the size check are counted in o_resp_cnt.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_resp_cnt <= 16'h0000;
    end else if (i_valid && i_dresp && !i_discard) begin
      o_resp_cnt <= o_resp_cnt + 16'h0001;
    end
  end
endmodule // acl_egress_sink
`default_nettype wire

// >>> acl_frame_header_rewriter_bench.sv
// Self-checking bench for the access-list frame header rewriter.
`timescale 1ns/10ps
`default_nettype none
module acl_frame_header_rewriter_bench import acl_rew_pkg::*;;
  localparam logic [47:0] DU = 48'h0000_1111_2222, SM = 48'h0100_3333_4444;
  localparam logic [47:0] DM = 48'h0100_5555_6666, AM = 48'h0a0b_0c0d_0e0f;
  localparam logic [127:0] SU = 128'h0a00_0001, DMC = 128'he000_0005, TB = 128'hc0a8_0003;
  logic i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_hdr_valid, i_is_ip4, i_is_ip6, i_is_l4;
  logic i_is_udp, i_is_dreq, i_policer_enable, i_act2_policer_enable, i_hop_preset_enable;
  logic i_port_rewrite_enable, i_mac_exchange_flag;
  logic [7:0] i_reg_addr, i_ttl, i_ptp_log_int, o_ttl, o_ptp_ctrl, o_ptp_log_int;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [47:0] i_dmac, i_smac, i_action_mac_value, i_nh_mac, o_dmac, o_smac;
  logic [127:0] i_sip, i_dip, o_sip, o_dip;
  logic [15:0] i_sport, i_dport, i_ip_len, i_udp_len, i_frame_len, i_ptp_flags, resp_seen;
  logic [15:0] i_match_identifier, i_match_identifier_mask, o_sport, o_dport, o_ip_len;
  logic [15:0] o_udp_len, o_frame_len, o_ptp_len, o_ptp_flags;
  logic [11:0] i_cl_vid, i_egr_vid, o_cl_vid;
  logic [9:0] i_cl_vsi, i_egr_rleg, o_cl_vsi, i_rewrite_command;
  logic [79:0] i_ptp_src_id, i_ptp_rx_ts, o_ptp_src_id, o_ptp_req_id, o_ptp_rx_ts;
  logic [3:0][79:0] i_ing_ts;
  logic [3:0] i_action_routing_mode, o_ptp_type;
  logic [4:0] i_policer_index, i_act2_policer_index, o_policer_index;
  logic [1:0] i_time_domain_select;
  logic [2:0] i_interval_value_field;
  logic o_valid, o_skip_dmac_rew, o_ip4_csum_redo, o_udp_csum_redo, o_udp_csum_zero;
  logic o_fcs_regen, o_discard, o_dresp;
  int err_total, compares;

  acl_frame_header_rewriter acl_frame_header_rewriter_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_hdr_valid(i_hdr_valid), .i_dmac(i_dmac), .i_smac(i_smac),
    .i_is_ip4(i_is_ip4), .i_is_ip6(i_is_ip6), .i_is_l4(i_is_l4), .i_is_udp(i_is_udp),
    .i_sip(i_sip), .i_dip(i_dip), .i_ttl(i_ttl), .i_sport(i_sport), .i_dport(i_dport),
    .i_ip_len(i_ip_len), .i_udp_len(i_udp_len), .i_frame_len(i_frame_len),
    .i_cl_vid(i_cl_vid), .i_cl_vsi(i_cl_vsi), .i_is_dreq(i_is_dreq),
    .i_ptp_flags(i_ptp_flags), .i_ptp_src_id(i_ptp_src_id), .i_ptp_rx_ts(i_ptp_rx_ts),
    .i_ptp_log_int(i_ptp_log_int), .i_ing_ts(i_ing_ts),
    .i_action_routing_mode(i_action_routing_mode), .i_action_mac_value(i_action_mac_value),
    .i_rewrite_command(i_rewrite_command), .i_policer_enable(i_policer_enable),
    .i_policer_index(i_policer_index), .i_act2_policer_enable(i_act2_policer_enable),
    .i_act2_policer_index(i_act2_policer_index), .i_hop_preset_enable(i_hop_preset_enable),
    .i_port_rewrite_enable(i_port_rewrite_enable), .i_match_identifier(i_match_identifier),
    .i_match_identifier_mask(i_match_identifier_mask),
    .i_time_domain_select(i_time_domain_select), .i_mac_exchange_flag(i_mac_exchange_flag),
    .i_interval_value_field(i_interval_value_field), .i_nh_mac(i_nh_mac),
    .i_egr_vid(i_egr_vid), .i_egr_rleg(i_egr_rleg), .o_valid(o_valid), .o_dmac(o_dmac),
    .o_smac(o_smac), .o_sip(o_sip), .o_dip(o_dip), .o_ttl(o_ttl), .o_sport(o_sport),
    .o_dport(o_dport), .o_ip_len(o_ip_len), .o_udp_len(o_udp_len),
    .o_frame_len(o_frame_len), .o_cl_vid(o_cl_vid), .o_cl_vsi(o_cl_vsi),
    .o_policer_index(o_policer_index), .o_skip_dmac_rew(o_skip_dmac_rew),
    .o_ip4_csum_redo(o_ip4_csum_redo), .o_udp_csum_redo(o_udp_csum_redo),
    .o_udp_csum_zero(o_udp_csum_zero), .o_fcs_regen(o_fcs_regen), .o_discard(o_discard),
    .o_dresp(o_dresp), .o_ptp_type(o_ptp_type), .o_ptp_ctrl(o_ptp_ctrl),
    .o_ptp_len(o_ptp_len), .o_ptp_flags(o_ptp_flags), .o_ptp_src_id(o_ptp_src_id),
    .o_ptp_req_id(o_ptp_req_id), .o_ptp_rx_ts(o_ptp_rx_ts), .o_ptp_log_int(o_ptp_log_int)
  );

  acl_egress_sink acl_egress_sink_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_valid(o_valid), .i_dresp(o_dresp),
    .i_discard(o_discard), .o_resp_cnt(resp_seen)
  );

  always #50 i_core_clk = ~i_core_clk;

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic cmp(input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1;
    cmp(exp, o_reg_rdata);
  endtask

  task automatic hdr(input logic [3:0] m, input logic [47:0] d, input logic [9:0] c);
    @(posedge i_core_clk);
    i_hdr_valid <= 1'b1;
    i_action_routing_mode <= m;
    i_dmac <= d;
    i_rewrite_command <= c;
    @(posedge i_core_clk);
    i_hdr_valid <= 1'b0;
    #1;
    cmp(1'b1, o_valid);
  endtask

  task automatic mode_chk(input logic [3:0] m, input logic [47:0] d, input logic [47:0] ed,
                          input logic [47:0] es, input logic [127:0] esip,
                          input logic [127:0] edip);
    logic ipc;
    ipc = (m >= 4'h5) && (m <= 4'h8);
    hdr(m, d, 10'h000);
    cmp(ed, o_dmac);
    cmp(es, o_smac);
    cmp(esip, o_sip);
    cmp(edip, o_dip);
    cmp(ipc ? 8'h22 : 8'h40, o_ttl);
    cmp(ipc, o_ip4_csum_redo);
    cmp(1'b1, o_fcs_regen);
  endtask

  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(4000 * 100);
    err_total++;
    print_verdict();
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    {i_core_clk, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_hdr_valid, i_dmac, i_is_ip6,
     i_is_l4, i_is_dreq, i_sport, i_dport, i_ing_ts, i_action_routing_mode, i_rewrite_command,
     i_act2_policer_enable, i_act2_policer_index, i_port_rewrite_enable, i_match_identifier,
     i_match_identifier_mask, i_time_domain_select} = '0;
    err_total = 0;
    compares = 0;
    i_rst = 1'b1;
    i_smac = SM;
    i_sip = SU;
    i_dip = DMC;
    i_is_ip4 = 1'b1;
    i_is_udp = 1'b1;
    i_ttl = 8'h40;
    i_hop_preset_enable = 1'b1;
    i_policer_enable = 1'b0;
    i_policer_index = 5'h03;
    i_action_mac_value = AM;
    i_nh_mac = 48'h0200_7777_8888;
    i_egr_vid = 12'h0a5;
    i_egr_rleg = 10'h1c3;
    i_cl_vid = 12'h111;
    i_cl_vsi = 10'h055;
    i_ip_len = 16'h0040;
    i_udp_len = 16'h002c;
    i_frame_len = 16'd138;
    i_ptp_flags = 16'h0f0f;
    i_ptp_src_id = 80'h9999_aaaa_bbbb_cccc_dddd;
    i_ptp_rx_ts = 80'h7777_7777_7777_7777_7777;
    i_ptp_log_int = 8'h01;
    i_ing_ts[2] = 80'h2222_3333_4444_5555_6666;
    i_mac_exchange_flag = 1'b1;
    i_interval_value_field = 3'h3;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd_chk(ADDR_CTRL, 32'h0000_0010);
    rd_chk(ADDR_SWAP, 32'h0000_4040);
    rd_chk(ADDR_PORT, 32'h0000_0000);
    rd_chk(8'h30, 32'h0000_0000);
    wr(ADDR_SWAP, 32'h0018_3322);
    rd_chk(ADDR_SWAP, 32'h0018_3322);
    wr(8'h8c, TB[31:0]);
    mode_chk(4'h1, DU, AM, SM, SU, DMC);
    hdr(4'h1, DU, 10'h200);
    cmp({AM[47:24], DU[23:0]}, o_dmac);
    mode_chk(4'h2, DU, DU, AM, SU, DMC);
    mode_chk(4'h3, DU, SM, DU, SU, DMC);
    mode_chk(4'h3, DM, SM, AM, SU, DMC);
    mode_chk(4'h4, DU, SM, DU, SU, DMC);
    mode_chk(4'h4, DM, DM, AM, SU, DMC);
    mode_chk(4'h5, DU, SM, DU, TB, SU);
    mode_chk(4'h6, DM, DM, AM, TB, DMC);
    mode_chk(4'h7, DU, DU, SM, TB, SU);
    mode_chk(4'h8, DU, DU, AM, TB, SU);
    wr(8'h94, 32'hc0a8_0005);
    i_act2_policer_enable <= 1'b1;
    i_act2_policer_index <= 5'h05;
    mode_chk(4'h7, DU, DU, SM, 128'hc0a8_0005, SU);
    cmp(5'h05, o_policer_index);
    i_act2_policer_enable <= 1'b0;
    hdr(4'h0, DU, 10'h000);
    cmp(DU, o_dmac);
    cmp(1'b0, o_skip_dmac_rew);
    wr(ADDR_CTRL, 32'h0000_0013);
    hdr(4'h0, DU, 10'h000);
    cmp(i_nh_mac, o_dmac);
    cmp(1'b1, o_skip_dmac_rew);
    cmp(i_egr_vid, o_cl_vid);
    cmp(i_egr_rleg, o_cl_vsi);
    wr(ADDR_CTRL, 32'h0000_0014);
    hdr(4'h9, DU, 10'h000);
    cmp(i_nh_mac, o_dmac);
    cmp(i_egr_vid[9:0], o_cl_vsi);
    wr(ADDR_CTRL, 32'h0000_0018);
    wr(8'h50, 32'h1111_2222);
    wr(8'h54, 32'h3333_4444);
    wr(8'h58, 32'h0000_abcd);
    wr(8'h5c, 32'h00f0_0055);
    wr(ADDR_PORT, 32'h0000_12a2);
    i_is_dreq <= 1'b1;
    i_time_domain_select <= 2'h1;
    for (int k = 1; k <= 2; k++) begin
      hdr(4'h0, DM, 10'(k));
      cmp(1'b1, o_dresp);
      cmp(4'h9, o_ptp_type);
      cmp(8'h03, o_ptp_ctrl);
      cmp(16'h0054, o_ptp_len);
      cmp(16'd148, o_frame_len);
      cmp(1'b0, o_discard);
      cmp(16'h0036, o_udp_len);
      cmp(16'h004a, o_ip_len);
      cmp(1'b1, o_udp_csum_zero);
      cmp(k == 1 ? i_ing_ts[2] : i_ptp_rx_ts, o_ptp_rx_ts);
      cmp(16'h0f5f, o_ptp_flags);
      cmp(80'h1111_2222_3333_4444_abea, o_ptp_src_id);
      cmp(i_ptp_src_id, o_ptp_req_id);
      cmp(8'hfb, o_ptp_log_int);
    end
    i_frame_len <= 16'd139;
    hdr(4'h0, DM, 10'h001);
    cmp(1'b1, o_discard);
    wr(ADDR_CTRL, 32'h0000_0010);
    hdr(4'h0, DM, 10'h001);
    cmp(1'b0, o_dresp);
    cmp(16'h0000, o_ptp_len);
    i_port_rewrite_enable <= 1'b1;
    i_is_l4 <= 1'b1;
    i_match_identifier <= 16'h1234;
    i_match_identifier_mask <= 16'h5678;
    hdr(4'h0, DU, 10'h000);
    cmp(16'h1234, o_sport);
    cmp(16'h5678, o_dport);
    cmp(1'b1, o_udp_csum_zero);
    i_is_ip4 <= 1'b0;
    i_is_ip6 <= 1'b1;
    hdr(4'h7, DU, 10'h000);
    cmp(DMC, o_sip);
    cmp(SU, o_dip);
    cmp(8'h33, o_ttl);
    cmp(1'b1, o_udp_csum_redo);
    cmp(1'b0, o_udp_csum_zero);
    cmp(1'b0, o_ip4_csum_redo);
    rd_chk(ADDR_STAT, 32'h0001_0002);
    cmp(16'h0002, resp_seen);
    print_verdict();
  end
endmodule // acl_frame_header_rewriter_bench
`default_nettype wire
